// >>> tcf_pkg.sv
// Purpose: shared constants and types of the timer configuration slice
// Assumes: 32-bit AXI4-Lite register bus, byte addresses below
// Notes: all configuration state clears to zero at reset
package tcf_pkg;

	// ==========================================
	// Register byte addresses
	localparam logic [7:0] ADDR_CONF = 8'h00;
	localparam logic [7:0] ADDR_FLTPOL = 8'h04;
	localparam logic [7:0] ADDR_SYNCONF = 8'h08;
	localparam logic [7:0] ADDR_MODE = 8'h0C;
	localparam logic [7:0] ADDR_STAT = 8'h10;
	localparam logic [7:0] ADDR_CLR = 8'h14;
	localparam logic [7:0] ADDR_IEN = 8'h18;
	localparam logic [7:0] ADDR_TRIG = 8'h1C;

	// ==========================================
	// Field positions and widths
	localparam int CONF_EXPORT = 10;
	localparam int CONF_IMPORT = 9;
	localparam int CONF_DBG_LO = 6;
	localparam int RATIO_W = 5;
	localparam int FLT_N = 4;
	localparam int TRIG_N = 3;
	localparam int EV_N = 3;
	localparam int SYN_CNT_LO = 16;
	localparam int SYN_KEEP = 0;
	localparam int MODE_WRITE_PROTECT_DISABLE = 2;
	localparam int EV_OVF = 0;
	localparam int EV_FAULT = 1;
	localparam int EV_TRIG = 2;

	// ==========================================
	// Writable bit masks and reset value
	localparam logic [31:0] CONF_MASK = 32'h000006DF;
	localparam logic [31:0] FLTPOL_MASK = 32'h0000000F;
	localparam logic [31:0] SYNCONF_MASK = 32'h001F0001;
	localparam logic [31:0] MODE_MASK = 32'h00000004;
	localparam logic [31:0] REG_RESET = 32'h00000000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Synchronisation starts, one per buffered target
	typedef struct packed {
		logic override_sync;
		logic invert_sync;
		logic mask_sync;
		logic buffer_sync;
		logic counter_sync;
	} tcf_sync_s;

endpackage : tcf_pkg

// >>> tcf_timer_config.sv
// Purpose: configuration, fault polarity and hardware-trigger sync enables
// Assumes: ovf_in and cnt_run come from logic on aclk; pins are async
// Notes: one AXI4-Lite write and one read at a time, answered in order
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.

// Behaviour
// - Reserved bits of the three configuration registers read zero, writes ignored.
// - Time base output is driven only while the export enable is one.
// - Import enable one gates counting by the external time base, else not.
// - Two-bit debug selector chooses timer behaviour in debug mode.
// - Ratio zero sets the overflow flag on every overflow.
// - Ratio N sets the flag once, then skips the next N overflows.
// - Each fault input has its own polarity bit, bits 3 to 0.
// - Polarity zero treats a high input as a fault.
// - Polarity one treats a low input as a fault.
// - Polarity bits are written only while write-protect-disable is one.
// - Bit 20 lets a hardware trigger start override register sync.
// - Bit 19 lets a hardware trigger start invert register sync.
// - Bit 18 lets a hardware trigger start output mask sync.
// - Bit 17 lets a hardware trigger sync modulo, initial, channel values.
// - Bit 16 lets a hardware trigger start counter sync.
// - Keep mode zero clears trigger flag j on trigger j, one keeps it.
module tcf_timer_config (
	// Clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Timer core
	input wire logic ovf_in,
	input wire logic cnt_run,
	output logic overflow_flag,
	output logic count_gate,
	output logic [1:0] debug_behaviour_sel,
	output tcf_pkg::tcf_sync_s sync_start,
	output logic [2:0] trigger_j_flag,
	// Pins and sibling timers
	input wire logic [3:0] fault_pin,
	input wire logic [2:0] hw_trig_pin,
	input wire logic time_base_in,
	output logic [3:0] fault_active,
	output logic time_base_out,
	// Interrupt
	output logic irq
);

	// ==========================================
	// State
	typedef struct packed {
		logic awrdy;
		logic wrdy;
		logic aw_got;
		logic w_got;
		logic [7:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arrdy;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [31:0] conf;
		logic [31:0] fltpol;
		logic [31:0] synconf;
		logic [31:0] mode;
		logic [2:0] stat;
		logic [2:0] ien;
		logic [2:0] trig;
		logic [4:0] skip;
		logic [3:0] flt_s1;
		logic [3:0] flt_s2;
		logic [2:0] hw_s1;
		logic [2:0] hw_s2;
		logic [2:0] hw_d;
		logic tb_s1;
		logic tb_s2;
		logic tb_out;
		logic tb_use;
		logic [3:0] fault;
		logic [4:0] sync_go;
		logic irq;
	} tcf_state_s;

	tcf_state_s s;
	tcf_state_s next_s;

	// Helpers, wr_fire and trig_det shared with the checks below
	logic wr_fire;
	logic [2:0] trig_det;
	logic [2:0] ev;

	// ==========================================
	// Functions
	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] wd,
		input logic [3:0] st,
		input logic [31:0] msk
	);
		logic [31:0] m;
		m = '0;
		for (int b = 0; b < 4; b++) begin
			m[b*8 +: 8] = {8{st[b]}};
		end
		return ((old & ~m) | (wd & m)) & msk;
	endfunction : merge

	function automatic logic mapped(input logic [7:0] a);
		return a == tcf_pkg::ADDR_CONF || a == tcf_pkg::ADDR_FLTPOL ||
			a == tcf_pkg::ADDR_SYNCONF || a == tcf_pkg::ADDR_MODE ||
			a == tcf_pkg::ADDR_STAT || a == tcf_pkg::ADDR_CLR ||
			a == tcf_pkg::ADDR_IEN || a == tcf_pkg::ADDR_TRIG;
	endfunction : mapped

	function automatic logic [31:0] rd(
		input logic [7:0] a,
		input tcf_state_s q
	);
		logic [31:0] d;
		d = '0;
		unique case (a)
			tcf_pkg::ADDR_CONF: d = q.conf;
			tcf_pkg::ADDR_FLTPOL: d = q.fltpol;
			tcf_pkg::ADDR_SYNCONF: d = q.synconf;
			tcf_pkg::ADDR_MODE: d = q.mode;
			tcf_pkg::ADDR_STAT: d = {29'h0, q.stat};
			tcf_pkg::ADDR_IEN: d = {29'h0, q.ien};
			tcf_pkg::ADDR_TRIG: d = {29'h0, q.trig};
			default: d = '0;
		endcase
		return d;
	endfunction : rd

	// ==========================================
	// Next state
	always_comb begin
		logic [2:0] clr;
		logic ovf_hit;
		logic conf_wr;
		clr = '0;
		ovf_hit = 1'b0;
		conf_wr = 1'b0;
		next_s = s;

		// Pin synchronisers, first stage read only by the second
		next_s.flt_s1 = fault_pin;
		next_s.flt_s2 = s.flt_s1;
		next_s.hw_s1 = hw_trig_pin;
		next_s.hw_s2 = s.hw_s1;
		next_s.hw_d = s.hw_s2;
		next_s.tb_s1 = time_base_in;
		next_s.tb_s2 = s.tb_s1;

		// Write address and data may arrive in either order
		if (s_axi_awvalid && s.awrdy) begin
			next_s.aw_got = 1'b1;
			next_s.waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s.wrdy) begin
			next_s.w_got = 1'b1;
			next_s.wdata = s_axi_wdata;
			next_s.wstrb = s_axi_wstrb;
		end
		wr_fire = s.aw_got && s.w_got && !s.bvalid;
		if (wr_fire) begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = mapped(s.waddr) ? tcf_pkg::RESP_OKAY
				: tcf_pkg::RESP_SLVERR;
			unique case (s.waddr)
				tcf_pkg::ADDR_CONF: begin
					next_s.conf = merge(s.conf, s.wdata, s.wstrb,
						tcf_pkg::CONF_MASK);
					conf_wr = s.wstrb[0];
				end
				tcf_pkg::ADDR_FLTPOL: begin
					if (s.mode[tcf_pkg::MODE_WRITE_PROTECT_DISABLE]) begin
						next_s.fltpol = merge(s.fltpol, s.wdata,
							s.wstrb, tcf_pkg::FLTPOL_MASK);
					end
				end
				tcf_pkg::ADDR_SYNCONF: begin
					next_s.synconf = merge(s.synconf, s.wdata,
						s.wstrb, tcf_pkg::SYNCONF_MASK);
				end
				tcf_pkg::ADDR_MODE: begin
					next_s.mode = merge(s.mode, s.wdata, s.wstrb,
						tcf_pkg::MODE_MASK);
				end
				tcf_pkg::ADDR_CLR: begin
					if (s.wstrb[0]) begin
						clr = s.wdata[2:0];
					end
				end
				tcf_pkg::ADDR_IEN: begin
					if (s.wstrb[0]) begin
						next_s.ien = s.wdata[2:0];
					end
				end
				tcf_pkg::ADDR_TRIG: begin
					if (s.wstrb[0]) begin
						next_s.trig = s.wdata[2:0];
					end
				end
				default: begin
				end
			endcase
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		// No new write part is taken until the response has gone
		next_s.awrdy = !next_s.aw_got && !next_s.bvalid;
		next_s.wrdy = !next_s.w_got && !next_s.bvalid;

		// Read channel
		if (s_axi_arvalid && s.arrdy) begin
			next_s.rvalid = 1'b1;
			next_s.rdata = rd(s_axi_araddr, s);
			next_s.rresp = mapped(s_axi_araddr) ? tcf_pkg::RESP_OKAY
				: tcf_pkg::RESP_SLVERR;
		end else if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end
		next_s.arrdy = !next_s.rvalid;

		// Overflow flag ratio
		if (ovf_in) begin
			if (s.skip == '0) begin
				ovf_hit = 1'b1;
				next_s.skip = s.conf[tcf_pkg::RATIO_W-1:0];
			end else begin
				next_s.skip = s.skip - 5'h01;
			end
		end
		// Rewriting the ratio restarts the pattern at a flagged overflow
		if (conf_wr) begin
			next_s.skip = '0;
		end

		// Fault polarity: a set bit inverts the input
		next_s.fault = s.flt_s2 ^ s.fltpol[tcf_pkg::FLT_N-1:0];

		// Hardware triggers count only while their flag is armed
		trig_det = s.hw_s2 & ~s.hw_d & s.trig;
		if (!s.synconf[tcf_pkg::SYN_KEEP]) begin
			next_s.trig = next_s.trig & ~trig_det;
		end
		next_s.sync_go = (trig_det != '0)
			? s.synconf[tcf_pkg::SYN_CNT_LO +: 5]
			: 5'h00;

		// Global time base
		next_s.tb_out = s.conf[tcf_pkg::CONF_EXPORT] && cnt_run;
		next_s.tb_use = s.conf[tcf_pkg::CONF_IMPORT]
			? s.tb_s2 : 1'b1;

		// Sticky events: a new event beats a clear in the same cycle
		ev = '0;
		ev[tcf_pkg::EV_OVF] = ovf_hit;
		ev[tcf_pkg::EV_FAULT] = (next_s.fault & ~s.fault) != '0;
		ev[tcf_pkg::EV_TRIG] = trig_det != '0;
		next_s.stat = (s.stat & ~clr) | ev;
		next_s.irq = (next_s.stat & next_s.ien) != '0;
	end

	// ==========================================
	// Registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.awrdy <= 1'b1;
			s.wrdy <= 1'b1;
			s.arrdy <= 1'b1;
			s.conf <= tcf_pkg::REG_RESET;
			s.fltpol <= tcf_pkg::REG_RESET;
			s.synconf <= tcf_pkg::REG_RESET;
			s.tb_use <= 1'b1;
		end else if (ce) begin
			s <= next_s;
		end
	end

	// ==========================================
	// Outputs, all straight from the state
	assign s_axi_awready = s.awrdy;
	assign s_axi_wready = s.wrdy;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = s.arrdy;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign overflow_flag = s.stat[tcf_pkg::EV_OVF];
	assign count_gate = s.tb_use;
	assign debug_behaviour_sel = s.conf[tcf_pkg::CONF_DBG_LO +: 2];
	assign sync_start = s.sync_go;
	assign trigger_j_flag = s.trig;
	assign fault_active = s.fault;
	assign time_base_out = s.tb_out;
	assign irq = s.irq;

	// ==========================================
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence trig_seen;
		ce && trig_det != '0;
	endsequence

	sequence polwrite_locked;
		ce && wr_fire && s.waddr == tcf_pkg::ADDR_FLTPOL &&
			!s.mode[tcf_pkg::MODE_WRITE_PROTECT_DISABLE];
	endsequence

	rsvd_zero_a: assert property (
		(s.conf & ~tcf_pkg::CONF_MASK) == '0 &&
		(s.fltpol & ~tcf_pkg::FLTPOL_MASK) == '0 &&
		(s.synconf & ~tcf_pkg::SYNCONF_MASK) == '0)
		else $error("reserved bit set");

	tb_export_a: assert property (
		ce && !s.conf[tcf_pkg::CONF_EXPORT] |=> !time_base_out)
		else $error("time base driven while export off");

	tb_import_a: assert property (
		ce |=> count_gate == ($past(s.conf[tcf_pkg::CONF_IMPORT])
			? $past(s.tb_s2) : 1'b1))
		else $error("count gate wrong");

	ovf_every_a: assert property (
		ce && ovf_in && s.skip == '0 |=> overflow_flag)
		else $error("overflow not flagged");

	ovf_skip_a: assert property (
		ce && ovf_in && s.skip != '0 && !wr_fire
		|=> s.skip == $past(s.skip) - 5'h01)
		else $error("skip count wrong");

	fault_pol_a: assert property (
		ce |=> fault_active == ($past(s.flt_s2)
			^ $past(s.fltpol[3:0])))
		else $error("fault polarity wrong");

	pol_lock_a: assert property (
		polwrite_locked |=> $stable(s.fltpol))
		else $error("locked polarity changed");

	hw_sync_a: assert property (
		trig_seen |=> sync_start == $past(s.synconf[20:16]))
		else $error("sync start mismatch");

	no_sync_a: assert property (
		ce && trig_det == '0 |=> sync_start == '0)
		else $error("sync start without trigger");

	trig_keep_a: assert property (
		trig_seen ##0 (!s.synconf[0] && !wr_fire)
		|=> (trigger_j_flag & $past(trig_det)) == '0)
		else $error("trigger flag not cleared");

	wr_resp_a: assert property (
		ce && wr_fire |=> s_axi_bvalid)
		else $error("write not answered");

endmodule : tcf_timer_config

// >>> tcf_sibling_timer.sv
// Purpose: model of a sibling timer that exports a global time base
// Assumes: shares aclk with the block under test
// Notes: the bench decides when the sibling counter runs
module tcf_sibling_timer (
	// Clock
	input wire logic aclk,
	// Control from the bench
	input wire logic run,
	// Shared time base
	output logic time_base
);
	timeunit 1ns;
	timeprecision 1ps;

	// Export is always enabled here, so the line follows the run state
	always_ff @(posedge aclk) begin
		time_base <= run;
	end
endmodule : tcf_sibling_timer

// >>> tcf_timer_config_tb_top.sv
// Purpose: self-checking bench of the timer configuration slice
// Assumes: register bus answers well within the cycle ceiling
// Notes: a timeout counts as a mismatch
module tcf_timer_config_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic aclk, aresetn, ce, ovf_in, cnt_run, sib_run, time_base_in;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, overflow_flag, count_gate;
	logic time_base_out, irq;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb, fault_pin, fault_active;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp, debug_behaviour_sel;
	logic [2:0] hw_trig_pin, trigger_j_flag;
	tcf_pkg::tcf_sync_s sync_start;
	int fails = 0;
	int n_compared = 0;
	int cyc = 0;

	// ==========================================
	// Design and sibling
	tcf_timer_config uut (.aclk, .aresetn, .ce, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ovf_in,
		.cnt_run, .overflow_flag, .count_gate, .debug_behaviour_sel,
		.sync_start, .trigger_j_flag, .fault_pin, .hw_trig_pin,
		.time_base_in, .fault_active, .time_base_out, .irq);
	tcf_sibling_timer sib (.aclk, .run(sib_run), .time_base(time_base_in));

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// ==========================================
	// Checking and bus tasks
	task automatic complete_run;
		if (fails == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			complete_run();
		end
	end

	task automatic chk(input string nm, input logic [31:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// Address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1 && !aw) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready === 1'b1 && !w) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		resp = s_axi_bresp;
	endtask : wr

	task automatic rdx(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		rd = s_axi_rdata;
		resp = s_axi_rresp;
	endtask : rdx

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		rdx(a);
		chk("read", rd, e);
	endtask : rdc

	task automatic pulse_ovf;
		ovf_in <= 1'b1;
		@(posedge aclk);
		ovf_in <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask : pulse_ovf

	task automatic ovf_seq(input logic [4:0] ratio);
		logic e;
		wr(tcf_pkg::ADDR_CONF, 32'(ratio));
		for (int i = 0; i < 7; i++) begin
			pulse_ovf();
			e = (i % (int'(ratio) + 1)) == 0;
			chk("ovf flag", 32'(overflow_flag), 32'(e));
			chk("irq", 32'(irq), 32'(e));
			wr(tcf_pkg::ADDR_CLR, 32'h1);
		end
	endtask : ovf_seq

	task automatic trig(input int j, input logic [4:0] es, input logic [2:0] ef);
		logic [4:0] got;
		got = 5'h00;
		hw_trig_pin[j] <= 1'b1;
		repeat (8) begin
			@(posedge aclk);
			if (sync_start != 5'h00)
				got = sync_start;
		end
		hw_trig_pin[j] <= 1'b0;
		repeat (4) @(posedge aclk);
		chk("sync", 32'(got), 32'(es));
		chk("trig flags", 32'(trigger_j_flag), 32'(ef));
	endtask : trig

	// ==========================================
	// Test sequence
	initial begin
		aresetn = 1'b0;
		ce = 1'b1;
		ovf_in = 1'b0;
		cnt_run = 1'b0;
		sib_run = 1'b0;
		fault_pin = 4'h0;
		hw_trig_pin = 3'h0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'hF;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(tcf_pkg::ADDR_CONF, 32'h0);
		rdc(tcf_pkg::ADDR_FLTPOL, 32'h0);
		rdc(tcf_pkg::ADDR_SYNCONF, 32'h0);
		chk("gate", 32'(count_gate), 32'h1);
		wr(tcf_pkg::ADDR_CONF, 32'hFFFFFFFF);
		rdc(tcf_pkg::ADDR_CONF, 32'h000006DF);
		chk("debug", 32'(debug_behaviour_sel), 32'h3);
		cnt_run <= 1'b1;
		repeat (6) @(posedge aclk);
		chk("gate", 32'(count_gate), 32'h0);
		chk("tb out", 32'(time_base_out), 32'h1);
		sib_run <= 1'b1;
		repeat (6) @(posedge aclk);
		chk("gate", 32'(count_gate), 32'h1);
		sib_run <= 1'b0;
		wr(tcf_pkg::ADDR_CONF, 32'h00000040);
		repeat (6) @(posedge aclk);
		chk("debug", 32'(debug_behaviour_sel), 32'h1);
		chk("gate", 32'(count_gate), 32'h1);
		chk("tb out", 32'(time_base_out), 32'h0);
		wr(tcf_pkg::ADDR_IEN, 32'h1);
		ovf_seq(5'd0);
		ovf_seq(5'd2);
		ovf_seq(5'd31);
		// Interrupt masked while the flag stands, then unmasked
		// Ratio back to zero so the next overflow is flagged
		wr(tcf_pkg::ADDR_CONF, 32'h0);
		wr(tcf_pkg::ADDR_IEN, 32'h0);
		pulse_ovf();
		chk("ovf flag", 32'(overflow_flag), 32'h1);
		chk("irq masked", 32'(irq), 32'h0);
		wr(tcf_pkg::ADDR_IEN, 32'h1);
		repeat (2) @(posedge aclk);
		chk("irq", 32'(irq), 32'h1);
		wr(tcf_pkg::ADDR_CLR, 32'h1);
		rdc(tcf_pkg::ADDR_STAT, 32'h0);
		wr(tcf_pkg::ADDR_FLTPOL, 32'hF);
		rdc(tcf_pkg::ADDR_FLTPOL, 32'h0);
		wr(tcf_pkg::ADDR_MODE, 32'h4);
		wr(tcf_pkg::ADDR_FLTPOL, 32'hFFFFFFF5);
		rdc(tcf_pkg::ADDR_FLTPOL, 32'h5);
		repeat (5) @(posedge aclk);
		chk("fault", 32'(fault_active), 32'h5);
		fault_pin <= 4'hF;
		repeat (5) @(posedge aclk);
		chk("fault", 32'(fault_active), 32'hA);
		wr(tcf_pkg::ADDR_TRIG, 32'h7);
		wr(tcf_pkg::ADDR_SYNCONF, 32'hFFFFFFFF);
		rdc(tcf_pkg::ADDR_SYNCONF, 32'h001F0001);
		trig(0, 5'h1F, 3'h7);
		wr(tcf_pkg::ADDR_SYNCONF, 32'h00150000);
		trig(1, 5'h15, 3'h5);
		wr(tcf_pkg::ADDR_SYNCONF, 32'h000A0000);
		trig(2, 5'h0A, 3'h1);
		rdc(tcf_pkg::ADDR_STAT, 32'h6);
		// Unmapped place: write ignored, read zero, error response
		wr(8'h20, 32'h1);
		chk("bresp", 32'(resp), 32'(tcf_pkg::RESP_SLVERR));
		rdc(8'h20, 32'h0);
		chk("rresp", 32'(resp), 32'(tcf_pkg::RESP_SLVERR));
		// Clock enable low freezes all state, pin synchronisers too
		ce <= 1'b0;
		fault_pin <= 4'h0;
		repeat (5) @(posedge aclk);
		chk("fault frozen", 32'(fault_active), 32'hA);
		ce <= 1'b1;
		repeat (5) @(posedge aclk);
		chk("fault", 32'(fault_active), 32'h5);
		complete_run();
	end
endmodule : tcf_timer_config_tb_top
